// ### rtl/tsc_pkg.sv
// Shared constants, types and helpers of the temperature sensor serial port.
package tsc_pkg;

	// Settings register layout, most significant field first.
	typedef struct packed {
		logic       reserved;
		logic [1:0] resolution_sel;
		logic [1:0] fault_count_sel;
		logic       alarm_active_level;
		logic       alarm_mode_select;
		logic       standby_select;
	} tsc_cfg_t;

	// Register pointer codes.
	localparam logic [1:0] PTR_TEMP = 2'h0;
	localparam logic [1:0] PTR_CFG  = 2'h1;
	localparam logic [1:0] PTR_HYST = 2'h2;
	localparam logic [1:0] PTR_OVER = 2'h3;

	// Fixed upper part of the bus address; the straps supply the rest.
	localparam logic [3:0] DEV_ADDR_HI = 4'h9;

	// Reset values.
	localparam logic [7:0]  CFG_RESET  = 8'h00;
	localparam logic [15:0] TEMP_RESET = 16'h0000;
	localparam logic [15:0] OVER_RESET = 16'h5000;
	localparam logic [15:0] HYST_RESET = 16'h4b00;

	// Field positions and widths.
	localparam int CFG_RSVD_BIT = 7;
	localparam int BYTE_BITS    = 8;

	// Longest conversion time per resolution, in ms, and the clock in kHz.
	localparam int CONV_MS_9  = 150;
	localparam int CONV_MS_10 = 300;
	localparam int CONV_MS_11 = 600;
	localparam int CONV_MS_12 = 1200;
	localparam int CLK_KHZ    = 40000;

	// Keeps only the bits that the selected resolution produces.
	function automatic logic [15:0] tsc_res_mask(input logic [1:0] res);
		unique case (res)
			2'h0: tsc_res_mask = 16'hff80;
			2'h1: tsc_res_mask = 16'hffc0;
			2'h2: tsc_res_mask = 16'hffe0;
			2'h3: tsc_res_mask = 16'hfff0;
		endcase
	endfunction : tsc_res_mask

	// Consecutive out-of-limit results needed to trip the alarm.
	function automatic logic [2:0] tsc_fault_need(input logic [1:0] ft);
		unique case (ft)
			2'h0: tsc_fault_need = 3'h1;
			2'h1: tsc_fault_need = 3'h2;
			2'h2: tsc_fault_need = 3'h4;
			2'h3: tsc_fault_need = 3'h6;
		endcase
	endfunction : tsc_fault_need

endpackage : tsc_pkg

// ### rtl/tsc_thermostat.sv
// Thermostat fault counter and alarm state for both alarm modes.
`timescale 1ns/10ps
module tsc_thermostat
	import tsc_pkg::*;
(
	// Clock and reset.
	input  wire logic        clock_in,
	input  wire logic        sys_rst_in,
	// Settings and limits.
	input  wire tsc_cfg_t    cfg_in,
	input  wire logic [15:0] over_limit_in,
	input  wire logic [15:0] hysteresis_in,
	// Conversion results and register read events.
	input  wire logic        sample_in,
	input  wire logic [15:0] temp_in,
	input  wire logic        read_clear_in,
	// Alarm state, true while the alarm is asserted.
	output logic             active_out
);

	logic [2:0]  run;
	logic        expect_low;
	logic        mode_q;
	logic        mode_chg;
	logic [15:0] mask;
	logic        over;
	logic        under;
	logic        hit;
	logic        trigger;
	logic [2:0]  need;

	always_comb begin
		mask     = tsc_res_mask(cfg_in.resolution_sel);
		over     = $signed(temp_in & mask) > $signed(over_limit_in & mask);
		under    = $signed(temp_in & mask) < $signed(hysteresis_in & mask);
		need     = tsc_fault_need(cfg_in.fault_count_sel);
		mode_chg = mode_q != cfg_in.alarm_mode_select;
		if (cfg_in.alarm_mode_select) begin
			hit = expect_low ? under : over;
		end else begin
			hit = over & ~active_out;
		end
		trigger = sample_in & hit & ((run + 3'h1) >= need);
	end

	always_ff @(posedge clock_in) begin
		mode_q <= sys_rst_in ? 1'b0 : cfg_in.alarm_mode_select;
	end

	// A result inside the limits breaks the run of consecutive faults.
	always_ff @(posedge clock_in) begin
		if (sys_rst_in || mode_chg || trigger) begin
			run <= 3'h0;
		end else if (sample_in) begin
			run <= hit ? run + 3'h1 : 3'h0;
		end
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in || mode_chg) begin
			expect_low <= 1'b0;
		end else if (trigger && cfg_in.alarm_mode_select) begin
			expect_low <= ~expect_low;
		end
	end

	// A trip in the same cycle as a clearing read wins, so it is not lost.
	always_ff @(posedge clock_in) begin
		if (sys_rst_in || mode_chg) begin
			active_out <= 1'b0;
		end else if (trigger) begin
			active_out <= 1'b1;
		end else if (cfg_in.alarm_mode_select) begin
			if (read_clear_in || cfg_in.standby_select) begin
				active_out <= 1'b0;
			end
		end else if (sample_in && under) begin
			active_out <= 1'b0;
		end
	end

	default clocking @(posedge clock_in); endclocking
	default disable iff (sys_rst_in);

	a_trip_on_sample:
	assert property ($rose(active_out) |-> $past(sample_in) && $past(hit))
	else $error("Alarm tripped without an out-of-limit result.");

	a_int_read_clear:
	assert property (cfg_in.alarm_mode_select && read_clear_in && !trigger
		&& !mode_chg |=> !active_out)
	else $error("Interrupt alarm not cleared by a read.");

	a_single_fault:
	assert property (sample_in && hit && need == 3'h1 && !mode_chg
		|=> active_out)
	else $error("Fault count of one did not trip the alarm.");

	c_six_faults: cover property (trigger && need == 3'h6);

endmodule : tsc_thermostat

// ### rtl/tsc_serial_port.sv
// Two-wire target port, register file and alarm pin of the thermometer.
//
// Overview of operation
// - Settings byte: reserved, resolution, faults, polarity, mode, standby.
// - Reserved settings bit writable, always reads zero.
// - Settings register clears to zero at reset.
// - Resolution code picks bits and conversion time.
// - Fault code needs 1, 2, 4, 6 faults.
// - Polarity bit picks alarm pin active level.
// - Mode bit picks comparator or interrupt alarm.
// - Standby bit stops conversions and clears an interrupt-mode alarm.
// - Two-bit pointer selects one of four registers.
// - Pointer persists across transactions until rewritten.
// - Pointer resets to the temperature register.
// - Target only; data line pulled low only.
// - Bytes travel most significant bit first.
// - Data falling while clock high is START.
// - Data rising while clock high is STOP, idle.
// - Receiver holds data low through ninth clock.
// - Master NACK ends the device's read data.
// - Match address 1001 plus three strap levels.
// - Address bit eight: one read, zero write.
// - Repeated START restarts address decoding directly.
// - Reads return high byte first; the pair repeats until NACK.
// - Standby waits for the running conversion.
// - Alarm trips after enough consecutive faults.
`timescale 1ns/10ps
module tsc_serial_port
	import tsc_pkg::*;
#(
	parameter int CONV_CYC_9  = CONV_MS_9 * CLK_KHZ,
	parameter int CONV_CYC_10 = CONV_MS_10 * CLK_KHZ,
	parameter int CONV_CYC_11 = CONV_MS_11 * CLK_KHZ,
	parameter int CONV_CYC_12 = CONV_MS_12 * CLK_KHZ
) (
	// Clock and reset.
	input  wire logic        clock_in,
	input  wire logic        sys_rst_in,
	// Two-wire bus pins; the data pin is open drain.
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe_out,
	// Address straps.
	input  wire logic        addr_strap_hi_in,
	input  wire logic        addr_strap_mid_in,
	input  wire logic        addr_strap_lo_in,
	// Converter side.
	input  wire logic        conv_done_in,
	input  wire logic        conv_busy_in,
	input  wire logic [15:0] conv_temp_in,
	output logic [1:0]       resolution_sel_out,
	output logic [31:0]      conv_budget_out,
	output logic             standby_select_out,
	// Thermostat pin.
	output logic             temp_alarm_output_out
);

	if (CONV_CYC_9 < 1 || CONV_CYC_10 < CONV_CYC_9 ||
		CONV_CYC_11 < CONV_CYC_10 || CONV_CYC_12 < CONV_CYC_11) begin : g_chk
		$error("Conversion budgets must be positive and rising.");
	end

	typedef enum logic [2:0] {
		ST_IDLE, ST_ADDR, ST_PTR, ST_WR, ST_ACK, ST_RD, ST_MACK, ST_SKIP
	} tsc_state_t;

	tsc_state_t  st;
	tsc_state_t  after;
	logic [4:0]  sync1;
	logic [4:0]  sync2;
	logic        scl_q;
	logic        sda_q;
	logic        scl_s;
	logic        sda_s;
	logic        scl_rise;
	logic        scl_fall;
	logic        start_det;
	logic        stop_det;
	logic        receiving;
	logic        byte_done;
	logic        addr_match;
	logic [3:0]  bit_cnt;
	logic [7:0]  sh;
	logic        nack;
	logic        rd_second;
	logic [1:0]  wr_idx;
	logic        read_clear;
	logic [1:0]  pointer;
	tsc_cfg_t    cfg;
	logic [7:0]  cfg_rd;
	logic [15:0] temp;
	logic [15:0] over_limit;
	logic [15:0] hysteresis;
	logic [7:0]  wr_hold;
	logic [15:0] rd_word;
	logic        active;

	// Bus pins and straps come from outside the clock domain.
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			sync1 <= 5'h1f;
			sync2 <= 5'h1f;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			sync1 <= {scl_in, sda_in, addr_strap_hi_in, addr_strap_mid_in,
				addr_strap_lo_in};
			sync2 <= sync1;
			scl_q <= sync2[4];
			sda_q <= sync2[3];
		end
	end

	always_comb begin
		scl_s      = sync2[4];
		sda_s      = sync2[3];
		scl_rise   = scl_s & ~scl_q;
		scl_fall   = ~scl_s & scl_q;
		start_det  = scl_s & scl_q & sda_q & ~sda_s;
		stop_det   = scl_s & scl_q & ~sda_q & sda_s;
		receiving  = st == ST_ADDR || st == ST_PTR || st == ST_WR;
		byte_done  = receiving && scl_fall && bit_cnt == 4'(BYTE_BITS);
		addr_match = sh[7:1] == {DEV_ADDR_HI, sync2[2:0]};
		cfg_rd     = cfg;
		cfg_rd[CFG_RSVD_BIT] = 1'b0;
		unique case (pointer)
			PTR_TEMP: rd_word = temp;
			PTR_CFG:  rd_word = {cfg_rd, cfg_rd};
			PTR_HYST: rd_word = hysteresis;
			PTR_OVER: rd_word = over_limit;
		endcase
	end

	// The data pin is only ever pulled low; the enable carries the bit.
	always_ff @(posedge clock_in) begin
		sda_out <= 1'b0;
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			st         <= ST_IDLE;
			after      <= ST_IDLE;
			bit_cnt    <= 4'h0;
			sh         <= 8'h00;
			sda_oe_out <= 1'b0;
			nack       <= 1'b0;
			rd_second  <= 1'b0;
		end else if (start_det) begin
			st         <= ST_ADDR;
			bit_cnt    <= 4'h0;
			sda_oe_out <= 1'b0;
		end else if (stop_det) begin
			st         <= ST_IDLE;
			sda_oe_out <= 1'b0;
		end else begin
			unique case (st)
				ST_IDLE, ST_SKIP: begin
					sda_oe_out <= 1'b0;
				end
				ST_ADDR, ST_PTR, ST_WR: begin
					if (scl_rise && bit_cnt < 4'(BYTE_BITS)) begin
						sh      <= {sh[6:0], sda_s};
						bit_cnt <= bit_cnt + 4'h1;
					end else if (byte_done) begin
						bit_cnt <= 4'h0;
						if (st != ST_ADDR) begin
							st         <= ST_ACK;
							after      <= ST_WR;
							sda_oe_out <= 1'b1;
						end else if (addr_match) begin
							st         <= ST_ACK;
							after      <= sh[0] ? ST_RD : ST_PTR;
							sda_oe_out <= 1'b1;
						end else begin
							st <= ST_SKIP;
						end
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						st        <= after;
						bit_cnt   <= 4'h0;
						rd_second <= 1'b0;
						sh        <= rd_word[15:8];
						sda_oe_out <= after == ST_RD && !rd_word[15];
					end
				end
				ST_RD: begin
					if (scl_fall) begin
						if (bit_cnt == 4'(BYTE_BITS - 1)) begin
							st         <= ST_MACK;
							sda_oe_out <= 1'b0;
						end else begin
							sda_oe_out <= !sh[6];
							sh         <= {sh[6:0], 1'b0};
							bit_cnt    <= bit_cnt + 4'h1;
						end
					end
				end
				ST_MACK: begin
					if (scl_rise) begin
						nack <= sda_s;
					end else if (scl_fall) begin
						bit_cnt <= 4'h0;
						if (nack) begin
							st <= ST_SKIP;
						end else begin
							// Past the second byte the pair repeats.
							st         <= ST_RD;
							rd_second  <= ~rd_second;
							sh         <= rd_second ? rd_word[15:8] : rd_word[7:0];
							sda_oe_out <= rd_second ? !rd_word[15] : !rd_word[7];
						end
					end
				end
			endcase
		end
	end

	// Reads clear an interrupt-mode alarm; the address is the trigger.
	always_ff @(posedge clock_in) begin
		read_clear <= !sys_rst_in && st == ST_ADDR && byte_done && addr_match
			&& sh[0];
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			pointer <= PTR_TEMP;
		end else if (st == ST_PTR && byte_done) begin
			pointer <= sh[1:0];
		end
	end

	// Each write starts over at the first byte after a fresh pointer.
	always_ff @(posedge clock_in) begin
		if (sys_rst_in || (st == ST_PTR && byte_done)) begin
			wr_idx <= 2'h0;
		end else if (st == ST_WR && byte_done && wr_idx != 2'h3) begin
			wr_idx <= wr_idx + 2'h1;
		end
	end

	// Writes beyond the register's length are acknowledged and dropped.
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			cfg     <= CFG_RESET;
			over_limit <= OVER_RESET;
			hysteresis <= HYST_RESET;
			wr_hold <= 8'h00;
		end else if (st == ST_WR && byte_done) begin
			if (pointer == PTR_CFG && wr_idx == 2'h0) begin
				cfg <= sh;
			end
			if (wr_idx == 2'h0) begin
				wr_hold <= sh;
			end
			if (wr_idx == 2'h1 && pointer == PTR_OVER) begin
				over_limit <= {wr_hold, sh[7:4], 4'h0};
			end
			if (wr_idx == 2'h1 && pointer == PTR_HYST) begin
				hysteresis <= {wr_hold, sh[7:4], 4'h0};
			end
		end
	end

	// A conversion under way when standby is chosen still lands here.
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			temp <= TEMP_RESET;
		end else if (conv_done_in) begin
			temp <= conv_temp_in & tsc_res_mask(cfg.resolution_sel);
		end
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			standby_select_out <= 1'b0;
			resolution_sel_out <= 2'h0;
			conv_budget_out    <= 32'(CONV_CYC_9);
		end else begin
			standby_select_out <= cfg.standby_select && !conv_busy_in;
			resolution_sel_out <= cfg.resolution_sel;
			unique case (cfg.resolution_sel)
				2'h0: conv_budget_out <= 32'(CONV_CYC_9);
				2'h1: conv_budget_out <= 32'(CONV_CYC_10);
				2'h2: conv_budget_out <= 32'(CONV_CYC_11);
				2'h3: conv_budget_out <= 32'(CONV_CYC_12);
			endcase
		end
	end

	tsc_thermostat u_thermostat (
		.clock_in      (clock_in),
		.sys_rst_in    (sys_rst_in),
		.cfg_in        (cfg),
		.over_limit_in (over_limit),
		.hysteresis_in (hysteresis),
		.sample_in     (conv_done_in),
		.temp_in       (conv_temp_in & tsc_res_mask(cfg.resolution_sel)),
		.read_clear_in (read_clear),
		.active_out    (active)
	);

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			temp_alarm_output_out <= 1'b1;
		end else begin
			temp_alarm_output_out <= cfg.alarm_active_level ^ ~active;
		end
	end

	default clocking @(posedge clock_in); endclocking
	default disable iff (sys_rst_in);

	a_reset_state:
	assert property (@(posedge clock_in) disable iff (1'b0)
		sys_rst_in |=> cfg == CFG_RESET && pointer == PTR_TEMP)
	else $error("Settings or pointer not cleared by reset.");

	a_rsvd_reads_zero:
	assert property (st == ST_ACK && scl_fall && after == ST_RD
		&& pointer == PTR_CFG |=> sda_oe_out)
	else $error("Reserved settings bit read back as one.");

	a_foreign_addr:
	assert property (st == ST_ADDR && byte_done && !addr_match && !start_det
		&& !stop_det |=> st == ST_SKIP && !sda_oe_out)
	else $error("Foreign address was not ignored.");

	a_skip_released:
	assert property (st == ST_SKIP |-> !sda_oe_out)
	else $error("Data line driven during a foreign transaction.");

	a_pointer_kept:
	assert property (!(st == ST_PTR && byte_done) |=> $stable(pointer))
	else $error("Pointer changed without a pointer byte.");

	a_start_decode:
	assert property (start_det |=> st == ST_ADDR && bit_cnt == 4'h0
		&& !sda_oe_out)
	else $error("START did not restart address decoding.");

	a_stop_idle:
	assert property (stop_det && !start_det |=> st == ST_IDLE && !sda_oe_out)
	else $error("STOP did not return the port to idle.");

	a_ack_driven:
	assert property (byte_done && st != ST_ADDR && !start_det && !stop_det
		|=> sda_oe_out && st == ST_ACK)
	else $error("Received byte not acknowledged.");

	a_nack_ends:
	assert property (st == ST_MACK && scl_fall && nack && !start_det
		&& !stop_det |=> st == ST_SKIP ##1 !sda_oe_out)
	else $error("Transmission went on after NACK.");

	a_rw_route:
	assert property (st == ST_ADDR && byte_done && addr_match && !start_det
		&& !stop_det |=> after == ($past(sh[0]) ? ST_RD : ST_PTR))
	else $error("Direction bit routed the transfer wrongly.");

	a_standby_wait:
	assert property (conv_busy_in |=> !standby_select_out)
	else $error("Standby entered during a conversion.");

	a_alarm_level:
	assert property (1'b1 |=> temp_alarm_output_out
		== ($past(cfg.alarm_active_level) ^ ~$past(active)))
	else $error("Alarm pin level does not follow polarity.");

	c_read_two: cover property (st == ST_MACK && scl_fall && !nack
		&& rd_second);
	c_cfg_write: cover property (st == ST_WR && byte_done
		&& pointer == PTR_CFG);
	c_foreign: cover property (st == ST_SKIP);
	c_restart: cover property (start_det && st == ST_PTR);

endmodule : tsc_serial_port

// ### testbench/tsc_bus_master.sv
// Bus master model that drives the two-wire clock and data lines.
`timescale 1ns/10ps
module tsc_bus_master (
	// Clock and wired data level.
	input  wire logic clock_in,
	input  wire logic sda_in,
	// Bus drive; a high pull holds the data line low.
	output logic      scl_out,
	output logic      sda_pull_out
);
	initial begin
		scl_out      = 1'b1;
		sda_pull_out = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clock_in);
	endtask : tick

	// Each link clock half lasts four clocks, a 200 ns period. Data moves
	// three clocks after the fall, once the port has seen that fall.
	task automatic bit_slot(input logic b, output logic got);
		tick(3);
		sda_pull_out <= ~b;
		tick(1);
		scl_out <= 1'b1;
		tick(4);
		got = sda_in;
		scl_out <= 1'b0;
	endtask : bit_slot

	// From idle the first half only repeats the idle levels.
	task automatic start_cond();
		tick(3);
		sda_pull_out <= 1'b0;
		tick(1);
		scl_out <= 1'b1;
		tick(4);
		sda_pull_out <= 1'b1;
		tick(4);
		scl_out <= 1'b0;
	endtask : start_cond

	task automatic stop_cond();
		tick(3);
		sda_pull_out <= 1'b1;
		tick(1);
		scl_out <= 1'b1;
		tick(4);
		sda_pull_out <= 1'b0;
		tick(4);
	endtask : stop_cond

	task automatic put_byte(input logic [7:0] b, output logic ack);
		logic g;
		for (int i = 7; i >= 0; i--) begin
			bit_slot(b[i], g);
		end
		bit_slot(1'b1, ack);
	endtask : put_byte

	task automatic get_byte(input logic last, output logic [7:0] b);
		logic g;
		for (int i = 7; i >= 0; i--) begin
			bit_slot(1'b1, g);
			b[i] = g;
		end
		bit_slot(last, g);
	endtask : get_byte
endmodule : tsc_bus_master

// ### testbench/temp_sensor_serial_config_port_tb.sv
// Self-checking bench of the thermometer serial port.
`timescale 1ns/10ps
module temp_sensor_serial_config_port_tb;
	import tsc_pkg::*;
	localparam int C9 = 100;
	logic        clock_in, sys_rst_in, scl, m_pull, sda_line, a;
	logic        s_hi, s_mid, s_lo, conv_done, conv_busy;
	logic        sda_out, sda_oe_out, standby, alarm;
	logic [1:0]  res_out;
	logic [6:0]  addr;
	logic [7:0]  cf;
	logic [15:0] conv_temp, v, w;
	logic [31:0] budget, seed;
	int          err_count, cmp_count;
	int          need[4] = '{1, 2, 4, 6};

	// Open drain: either party pulling wins, the pull-up gives high.
	assign sda_line = ~(m_pull | (sda_oe_out & ~sda_out));

	tsc_bus_master i_master (.clock_in(clock_in), .sda_in(sda_line),
		.scl_out(scl), .sda_pull_out(m_pull));

	tsc_serial_port #(.CONV_CYC_9(C9), .CONV_CYC_10(2 * C9),
		.CONV_CYC_11(4 * C9), .CONV_CYC_12(8 * C9)) i_dut (
		.clock_in(clock_in), .sys_rst_in(sys_rst_in), .scl_in(scl),
		.sda_in(sda_line), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
		.addr_strap_hi_in(s_hi), .addr_strap_mid_in(s_mid),
		.addr_strap_lo_in(s_lo), .conv_done_in(conv_done),
		.conv_busy_in(conv_busy), .conv_temp_in(conv_temp),
		.resolution_sel_out(res_out), .conv_budget_out(budget),
		.standby_select_out(standby), .temp_alarm_output_out(alarm));

	// Xorshift step; the fixed start value keeps every run repeatable.
	function automatic void rng();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
	endfunction : rng

	function automatic logic [15:0] res_mask(input logic [1:0] r);
		return 16'hffff << (7 - r);
	endfunction : res_mask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: %s got %h want %h", $time, what,
				got, exp);
		end
	endtask : chk

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : print_verdict

	task automatic wr_reg(input logic [1:0] p, input logic [15:0] d,
		input int n);
		i_master.start_cond();
		i_master.put_byte({addr, 1'b0}, a);
		chk(a, 1'b0, "address ack");
		i_master.put_byte({6'h00, p}, a);
		chk(a, 1'b0, "pointer ack");
		for (int i = 0; i < n; i++) begin
			i_master.put_byte(d[15 - 8 * i -: 8], a);
			chk(a, 1'b0, "data ack");
		end
		i_master.stop_cond();
	endtask : wr_reg

	task automatic rd_reg(input logic sp, input logic [1:0] p, input int n,
		output logic [15:0] d);
		d = 16'h0000;
		i_master.start_cond();
		if (sp) begin
			i_master.put_byte({addr, 1'b0}, a);
			i_master.put_byte({6'h00, p}, a);
			i_master.start_cond();
		end
		i_master.put_byte({addr, 1'b1}, a);
		chk(a, 1'b0, "read ack");
		i_master.get_byte(n == 1, d[15:8]);
		if (n == 2) begin
			i_master.get_byte(1'b1, d[7:0]);
		end
		i_master.stop_cond();
		chk(sda_oe_out, 1'b0, "released");
	endtask : rd_reg

	// Call just after a rising edge.
	task automatic conv(input logic [15:0] t);
		conv_temp <= t;
		conv_busy <= 1'b1;
		conv_done <= 1'b1;
		@(posedge clock_in);
		conv_done <= 1'b0;
		conv_busy <= 1'b0;
		repeat (3) @(posedge clock_in);
	endtask : conv

	initial begin
		clock_in = 1'b0;
		forever #12.5 clock_in = ~clock_in;
	end

	initial begin
		repeat (90000) @(posedge clock_in);
		err_count++;
		print_verdict();
	end

	initial begin
		seed = 32'ha6dc21d3;
		err_count = 0;
		cmp_count = 0;
		sys_rst_in = 1'b1;
		conv_done = 1'b0;
		conv_busy = 1'b0;
		conv_temp = 16'h0000;
		rng();
		{s_hi, s_mid, s_lo} = seed[2:0];
		addr = {DEV_ADDR_HI, seed[2:0]};
		repeat (16) @(posedge clock_in);
		sys_rst_in <= 1'b0;
		repeat (8) @(posedge clock_in);
		chk(alarm, 1'b1, "alarm idle");
		chk(budget, C9, "budget at reset");
		rd_reg(1'b0, PTR_TEMP, 2, v);
		chk(v, 16'h0000, "temperature at reset");
		chk(sda_out, 1'b0, "pull only");
		rd_reg(1'b1, PTR_CFG, 1, v);
		chk(v[15:8], 8'h00, "settings at reset");
		rd_reg(1'b1, PTR_HYST, 2, v);
		chk(v, 16'h4b00, "hysteresis at reset");
		rd_reg(1'b1, PTR_OVER, 2, v);
		chk(v, 16'h5000, "over limit at reset");
		rng();
		v = seed[15:0];
		wr_reg(PTR_OVER, v, 2);
		for (int i = 0; i < 2; i++) begin
			rd_reg(1'b0, PTR_TEMP, 2, w);
			chk(w, v & 16'hfff0, "pointer kept");
		end
		wr_reg(PTR_OVER, 16'h5000, 2);
		rng();
		wr_reg(PTR_HYST, seed[15:0], 2);
		rd_reg(1'b0, PTR_TEMP, 2, w);
		chk(w, seed[15:0] & 16'hfff0, "hysteresis written");
		wr_reg(PTR_HYST, 16'h4b00, 2);
		// Every resolution code, standby off, reserved bit set on the first pass, other fields random.
		for (int i = 0; i < 4; i++) begin
			rng();
			cf = seed[7:0];
			cf[6:5] = i[1:0];
			cf[0] = 1'b0;
			if (i == 0) begin
				cf[7] = 1'b1;
			end
			wr_reg(PTR_CFG, {cf, 8'h00}, 1);
			rd_reg(1'b1, PTR_CFG, 1, w);
			chk(w[15:8], {1'b0, cf[6:0]}, "settings");
			chk(res_out, cf[6:5], "resolution");
			chk(budget, C9 << cf[6:5], "budget");
			rng();
			conv(seed[15:0]);
			rd_reg(1'b1, PTR_TEMP, 2, w);
			chk(w, seed[15:0] & res_mask(cf[6:5]), "temperature");
		end
		// Comparator mode over every fault count.
		for (int f = 0; f < 4; f++) begin
			wr_reg(PTR_CFG, {3'b000, f[1:0], 3'b000, 8'h00}, 1);
			for (int k = 1; k <= need[f]; k++) begin
				conv(16'h6000);
				chk(alarm, k != need[f], "fault count");
			end
			conv(16'h4000);
			chk(alarm, 1'b1, "comparator release");
		end
		wr_reg(PTR_CFG, 16'h0600, 1);
		chk(alarm, 1'b0, "high polarity idle");
		conv(16'h6000);
		chk(alarm, 1'b1, "interrupt trip");
		rd_reg(1'b1, PTR_TEMP, 2, w);
		chk(alarm, 1'b0, "interrupt cleared by read");
		conv(16'h4000);
		chk(alarm, 1'b1, "interrupt trip below hysteresis");
		wr_reg(PTR_CFG, 16'h0100, 1);
		chk(standby, 1'b1, "standby");
		rd_reg(1'b1, PTR_CFG, 1, w);
		chk(w[15:8], 8'h01, "port alive in standby");
		wr_reg(PTR_CFG, 16'h0000, 1);
		chk(standby, 1'b0, "wake");
		for (int i = 0; i < 4; i++) begin
			i_master.start_cond();
			i_master.put_byte({addr ^ (7'h01 << i), 1'b0}, a);
			chk(a, 1'b1, "foreign address");
			i_master.put_byte(8'h01, a);
			chk(a, 1'b1, "foreign data");
			i_master.stop_cond();
		end
		print_verdict();
	end
endmodule : temp_sensor_serial_config_port_tb
